// ==== logic/cap_pkg.sv ====
// package for the configuration access port: widths, timing, states
// assumes nothing beyond a SystemVerilog compiler
package cap_pkg;
  localparam int CAP_ADDR_W = 10;
  localparam int CAP_DATA_W = 16;
  localparam int CAP_DEPTH = 1024;
  // device answers this many port clock cycles after taking a request
  localparam logic [1:0] CAP_LATENCY = 2'h2;
  localparam logic [15:0] CAP_WORD_RESET = 16'h0000;
  // port clock made by the user end: divide-by-2N of the system clock
  localparam int CAP_CLOCK_NS = 5;
  localparam int CAP_PORT_PERIOD_NS = 40;
  localparam int CAP_DIV_HALF = CAP_PORT_PERIOD_NS / (2 * CAP_CLOCK_NS);
  localparam logic [3:0] CAP_DIV_HALF_M1 = 4'(CAP_DIV_HALF - 1);
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_ISSUE = 2'b01,
    CAP_WAIT = 2'b10,
    CAP_DONE = 2'b11
  } cap_user_state_t;
endpackage

// ==== logic/cap_if.sv ====
// interface joining the configuration port device end and the user end
// assumes the user end drives cfg_port_clock
`timescale 1ns/10ps
`default_nettype none
interface cap_if;
  import cap_pkg::*;
  logic cfg_port_clock;
  logic [CAP_ADDR_W-1:0] cfg_word_addr;
  logic [CAP_DATA_W-1:0] cfg_write_data;
  logic cfg_access_strobe;
  logic cfg_write_select;
  logic [CAP_DATA_W-1:0] cfg_read_data;
  logic cfg_access_done;
  modport device (
    input cfg_port_clock, cfg_word_addr, cfg_write_data, cfg_access_strobe, cfg_write_select,
    output cfg_read_data, cfg_access_done
  );
  modport user (
    output cfg_port_clock, cfg_word_addr, cfg_write_data, cfg_access_strobe, cfg_write_select,
    input cfg_read_data, cfg_access_done
  );
endinterface
`default_nettype wire

// ==== logic/cap_sync.sv ====
// two-flop level synchroniser
// assumes d comes from another clock domain
`timescale 1ns/10ps
`default_nettype none
module cap_sync (
  // clocking
  input wire logic clock,
  input wire logic rst,
  // data
  input wire logic d,
  output logic q
);
  logic meta_r;
  logic meta_nxt;
  logic q_r;
  logic q_nxt;
  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end
  assign q = q_r;
endmodule
`default_nettype wire

// ==== logic/cap_user.sv ====
// user end of the configuration access port: makes the port clock,
// issues single reads and writes from its own clock domain
// assumes the device end answers on cfg_access_done within a few port clocks
`timescale 1ns/10ps
`default_nettype none
module cap_user
  import cap_pkg::*;
(
  // clocking
  input wire logic clock,
  input wire logic rst,
  // request side
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [CAP_ADDR_W-1:0] req_addr,
  input wire logic [CAP_DATA_W-1:0] req_wdata,
  // answer side
  output logic rsp_valid,
  output logic [CAP_DATA_W-1:0] rsp_rdata,
  // port
  cap_if.user port
);
  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic pclk_r;
  logic pclk_nxt;
  logic fall;
  logic op_we_r;
  logic op_we_nxt;
  cap_user_state_t st_r;
  cap_user_state_t st_nxt;
  logic [CAP_ADDR_W-1:0] addr_r;
  logic [CAP_ADDR_W-1:0] addr_nxt;
  logic [CAP_DATA_W-1:0] wdata_r;
  logic [CAP_DATA_W-1:0] wdata_nxt;
  logic [CAP_DATA_W-1:0] rdata_r;
  logic [CAP_DATA_W-1:0] rdata_nxt;
  logic stb_r;
  logic stb_nxt;
  logic we_r;
  logic we_nxt;
  logic rsp_r;
  logic rsp_nxt;
  // port clock runs only while out of reset; held low otherwise
  always_comb begin
    div_nxt = div_r + 4'h1;
    pclk_nxt = pclk_r;
    if (div_r == CAP_DIV_HALF_M1) begin
      div_nxt = 4'h0;
      pclk_nxt = ~pclk_r;
    end
  end
  // strobe and select launch, and done is sampled, half a port cycle away from the device's edge
  assign fall = (div_r == CAP_DIV_HALF_M1) && pclk_r;
  // strobe changes only on the port clock falling phase, one port cycle wide
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    stb_nxt = stb_r;
    we_nxt = we_r;
    op_we_nxt = op_we_r;
    rsp_nxt = 1'b0;
    unique case (st_r)
      CAP_IDLE: begin
        if (req_valid) begin
          addr_nxt = req_addr;
          wdata_nxt = req_wdata;
          op_we_nxt = req_write;
          st_nxt = CAP_ISSUE;
        end
      end
      CAP_ISSUE: begin
        if (fall) begin
          stb_nxt = 1'b1;
          we_nxt = op_we_r;
          st_nxt = CAP_WAIT;
        end
      end
      CAP_WAIT: begin
        if (fall) begin
          stb_nxt = 1'b0;
          we_nxt = 1'b0;
          if (port.cfg_access_done) begin
            rdata_nxt = port.cfg_read_data;
            st_nxt = CAP_DONE;
          end
        end
      end
      CAP_DONE: begin
        rsp_nxt = 1'b1;
        st_nxt = CAP_IDLE;
      end
    endcase
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_r <= 4'h0;
      pclk_r <= 1'b0;
      st_r <= CAP_IDLE;
      addr_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
      stb_r <= 1'b0;
      we_r <= 1'b0;
      op_we_r <= 1'b0;
      rsp_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      pclk_r <= pclk_nxt;
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      stb_r <= stb_nxt;
      we_r <= we_nxt;
      op_we_r <= op_we_nxt;
      rsp_r <= rsp_nxt;
    end
  end
  assign port.cfg_port_clock = pclk_r;
  assign port.cfg_word_addr = addr_r;
  assign port.cfg_write_data = wdata_r;
  assign port.cfg_access_strobe = stb_r;
  assign port.cfg_write_select = we_r;
  assign req_ready = (st_r == CAP_IDLE);
  assign rsp_valid = rsp_r;
  assign rsp_rdata = rdata_r;
endmodule
`default_nettype wire

// ==== logic/cap_device.sv ====
// device end of the configuration access port: 1024 x 16 configuration
// words on the port clock, with the words also readable from the core clock
// assumes the port clock may stop or be held low when the port is unused
`timescale 1ns/10ps
`default_nettype none
module cap_device
  import cap_pkg::*;
(
  // core clocking
  input wire logic clock,
  input wire logic rst,

  // core side view of the words
  input wire logic [CAP_ADDR_W-1:0] core_addr,
  output logic [CAP_DATA_W-1:0] core_word,
  output logic core_write_seen,
  output logic busy,

  // port
  cap_if.device port
);
  // configuration words; written on the port clock only
  logic [CAP_DATA_W-1:0] mem [CAP_DEPTH];

  // access tracking, port clock domain
  logic take;
  logic last;
  logic pend_r;
  logic pend_nxt;
  logic pend_we_r;
  logic pend_we_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [CAP_ADDR_W-1:0] pend_addr_r;
  logic [CAP_ADDR_W-1:0] pend_addr_nxt;
  logic [CAP_DATA_W-1:0] pend_data_r;
  logic [CAP_DATA_W-1:0] pend_data_nxt;

  // answer, port clock domain
  logic [CAP_DATA_W-1:0] rdata_r;
  logic [CAP_DATA_W-1:0] rdata_nxt;
  logic done_r;
  logic done_nxt;

  // write event, port clock domain
  logic do_write;
  logic wr_tgl_r;
  logic wr_tgl_nxt;

  // core clock domain
  logic wr_tgl_s;
  logic busy_s;
  logic wr_tgl_d_r;
  logic wr_tgl_d_nxt;
  logic wr_seen_r;
  logic wr_seen_nxt;
  logic [CAP_DATA_W-1:0] core_word_r;
  logic [CAP_DATA_W-1:0] core_word_nxt;

  // a strobe during a pending access is ignored; the user end never sends one
  assign take = port.cfg_access_strobe && !pend_r;
  assign last = pend_r && (cnt_r == CAP_LATENCY);

  // port clock domain; reset acts on the rising edge of rst, as the port clock is held low in reset
  always_comb begin
    pend_nxt = pend_r;
    pend_we_nxt = pend_we_r;
    cnt_nxt = cnt_r;
    pend_addr_nxt = pend_addr_r;
    pend_data_nxt = pend_data_r;
    if (take) begin
      pend_nxt = 1'b1;
      pend_we_nxt = port.cfg_write_select;
      cnt_nxt = 2'h1;
      pend_addr_nxt = port.cfg_word_addr;
      pend_data_nxt = port.cfg_write_data;
    end else if (last) begin
      pend_nxt = 1'b0;
    end else if (pend_r) begin
      cnt_nxt = cnt_r + 2'h1;
    end
  end

  always_ff @(posedge port.cfg_port_clock or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
      pend_we_r <= 1'b0;
      cnt_r <= 2'h0;
      pend_addr_r <= '0;
      pend_data_r <= CAP_WORD_RESET;
    end else begin
      pend_r <= pend_nxt;
      pend_we_r <= pend_we_nxt;
      cnt_r <= cnt_nxt;
      pend_addr_r <= pend_addr_nxt;
      pend_data_r <= pend_data_nxt;
    end
  end

  // done is one port cycle wide; read data stands until the next read
  always_comb begin
    done_nxt = last;
    rdata_nxt = rdata_r;
    if (last && !pend_we_r) begin
      rdata_nxt = mem[pend_addr_r];
    end
  end

  always_ff @(posedge port.cfg_port_clock or posedge rst) begin
    if (rst) begin
      rdata_r <= CAP_WORD_RESET;
      done_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
    end
  end

  // a write lands at the edge that raises done, and flips the event toggle
  always_comb begin
    do_write = last && pend_we_r;
    wr_tgl_nxt = wr_tgl_r;
    if (do_write) begin
      wr_tgl_nxt = ~wr_tgl_r;
    end
  end

  always_ff @(posedge port.cfg_port_clock or posedge rst) begin
    if (rst) begin
      wr_tgl_r <= 1'b0;
    end else begin
      wr_tgl_r <= wr_tgl_nxt;
    end
  end

  // memory has no reset; contents are undefined until written
  always_ff @(posedge port.cfg_port_clock) begin
    if (do_write) begin
      mem[pend_addr_r] <= pend_data_r;
    end
  end

  assign port.cfg_read_data = rdata_r;
  assign port.cfg_access_done = done_r;

  // core domain: write events cross as a toggle, busy as a level
  cap_sync u_sync_wr (
    .clock(clock),
    .rst(rst),
    .d(wr_tgl_r),
    .q(wr_tgl_s)
  );

  cap_sync u_sync_busy (
    .clock(clock),
    .rst(rst),
    .d(pend_r),
    .q(busy_s)
  );

  // a toggle edge marks one completed write, one core clock wide
  always_comb begin
    wr_tgl_d_nxt = wr_tgl_s;
    wr_seen_nxt = wr_tgl_s ^ wr_tgl_d_r;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_tgl_d_r <= 1'b0;
      wr_seen_r <= 1'b0;
    end else begin
      wr_tgl_d_r <= wr_tgl_d_nxt;
      wr_seen_r <= wr_seen_nxt;
    end
  end

  // busy still covers the write edge for two clocks, so a held sample never tears;
  // the price is a stale view while an access is in flight
  always_comb begin
    core_word_nxt = core_word_r;
    if (!busy_s) begin
      core_word_nxt = mem[core_addr];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_word_r <= CAP_WORD_RESET;
    end else begin
      core_word_r <= core_word_nxt;
    end
  end

  assign core_word = core_word_r;
  assign core_write_seen = wr_seen_r;
  assign busy = busy_s;
endmodule
`default_nettype wire

// ==== tb/cap_monitor.sv ====
// checker for the configuration port wire
// assumes it sits beside the cap_if instance
`timescale 1ns/10ps
`default_nettype none
module cap_monitor
  import cap_pkg::*;
(
  // clocking
  input wire logic cfg_port_clock,
  input wire logic rst,
  // request
  input wire logic [CAP_ADDR_W-1:0] cfg_word_addr,
  input wire logic cfg_access_strobe,
  input wire logic cfg_write_select,
  // answer
  input wire logic [CAP_DATA_W-1:0] cfg_read_data,
  input wire logic cfg_access_done
);
  default clocking @(posedge cfg_port_clock); endclocking
  default disable iff (rst);
  sequence s_take;
    cfg_access_strobe;
  endsequence
  // done is sampled on the third port rise after the take
  sequence s_answer;
    ##3 cfg_access_done;
  endsequence
  property p_answer;
    s_take |-> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("no done after access");
  property p_one;
    s_take |=> !cfg_access_strobe;
  endproperty
  a_one: assert property (p_one) else $error("strobe too long");
  property p_we;
    cfg_write_select |-> cfg_access_strobe;
  endproperty
  a_we: assert property (p_we) else $error("select without strobe");
  property p_single;
    s_take |=> !cfg_access_strobe [*3];
  endproperty
  a_single: assert property (p_single) else $error("overlapping access");
  property p_pulse;
    cfg_access_done |=> !cfg_access_done;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_cause;
    cfg_access_done |-> $past(cfg_access_strobe, 3);
  endproperty
  a_cause: assert property (p_cause) else $error("done without access");
  property p_addr;
    s_take |=> $stable(cfg_word_addr) [*2];
  endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_rdata;
    $changed(cfg_read_data) |-> cfg_access_done;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
endmodule
`default_nettype wire

// ==== tb/tb_config_access_port.sv ====
// bench: user end and device end joined by cap_if
// assumes the user end makes the port clock
`timescale 1ns/10ps
`default_nettype none
module tb_config_access_port;
  import cap_pkg::*;
  logic clock = 1'h0;
  logic rst = 1'h0;
  logic req_valid = 1'h0;
  logic req_write = 1'h0;
  logic [9:0] req_addr = 10'h000;
  logic [15:0] req_wdata = 16'h0000;
  logic [9:0] core_addr = 10'h000;
  logic req_ready, rsp_valid, core_write_seen, busy;
  logic [15:0] rsp_rdata, core_word;
  logic [9:0] ad [3] = '{10'h000, 10'h3FF, 10'h155};
  logic [15:0] dt [3] = '{16'hA5C3, 16'h5A3C, 16'hFFFF};
  int fails = 0;
  int n_tests = 0;
  int n_stb = 0;
  int n_done = 0;
  int n_seen = 0;
  cap_if cap_if_i ();
  cap_user cap_user_i (.clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .port(cap_if_i));
  cap_device cap_device_i (.clock(clock), .rst(rst), .core_addr(core_addr), .core_word(core_word),
    .core_write_seen(core_write_seen), .busy(busy), .port(cap_if_i));
  cap_monitor cap_monitor_i (.cfg_port_clock(cap_if_i.cfg_port_clock), .rst(rst),
    .cfg_word_addr(cap_if_i.cfg_word_addr), .cfg_access_strobe(cap_if_i.cfg_access_strobe),
    .cfg_write_select(cap_if_i.cfg_write_select), .cfg_read_data(cap_if_i.cfg_read_data),
    .cfg_access_done(cap_if_i.cfg_access_done));
  initial forever #2.5 clock = ~clock;
  // strobe moves at the port clock fall and done at its rise: count each at the other edge
  always @(posedge cap_if_i.cfg_port_clock) n_stb += (cap_if_i.cfg_access_strobe === 1'h1);
  always @(negedge cap_if_i.cfg_port_clock) n_done += (cap_if_i.cfg_access_done === 1'h1);
  always @(negedge clock) n_seen += (core_write_seen === 1'h1);
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bound(input int k);
    if (k >= 200) begin
      fails++;
      finish_test();
    end
  endtask
  task automatic access(input logic w, input logic [9:0] a, input logic [15:0] d);
    int k;
    @(posedge clock);
    req_valid <= 1'h1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (req_ready !== 1'h1 && k < 200);
    bound(k);
    @(posedge clock);
    req_valid <= 1'h0;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (rsp_valid !== 1'h1 && k < 200);
    bound(k);
  endtask
  task automatic t_write_read();
    for (int i = 0; i < 3; i++)
      access(1'h1, ad[i], dt[i]);
    for (int i = 0; i < 3; i++) begin
      access(1'h0, ad[i], 16'h0000);
      chk("rsp_rdata", rsp_rdata, dt[i]);
      chk("cfg_read_data", cap_if_i.cfg_read_data, dt[i]);
      @(posedge clock);
      core_addr <= ad[i];
      @(posedge clock);
      @(negedge clock);
      chk("core_word", core_word, dt[i]);
    end
    chk("strobes", 16'(n_stb), 16'h0006);
    chk("dones", 16'(n_done), 16'h0006);
    chk("writes", 16'(n_seen), 16'h0003);
  endtask
  task automatic t_read_only();
    access(1'h0, 10'h3FF, 16'h0000);
    access(1'h0, 10'h3FF, 16'h0000);
    chk("reread", rsp_rdata, 16'h5A3C);
    chk("no write", 16'(n_seen), 16'h0003);
    chk("busy", {15'h0000, busy}, 16'h0000);
  endtask
  initial begin
    // a real rising edge, so the port clock flops reset while that clock is still
    rst <= 1'h1;
    repeat (3) @(posedge clock);
    chk("clk in reset", {15'h0000, cap_if_i.cfg_port_clock}, 16'h0000);
    rst <= 1'h0;
    t_write_read();
    t_read_only();
    finish_test();
  end
endmodule
`default_nettype wire
